// File: dv/cbx_exec_props.sv
`timescale 1ns/100ps
`include "cbx_defines.vh"
// port-level checks of the execution core
module cbx_exec_props #(
   parameter PC_W   = 16,
   parameter DISP_W = 7
) (
   input wire              clock_in,
   input wire              sys_rst_in,
   input wire              op_valid_in,
   input wire [4:0]        op_code_in,
   input wire [2:0]        op_flag_sel_in,
   input wire [DISP_W-1:0] op_disp_in,
   input wire              op_ready_out,
   input wire [PC_W-1:0]   pc_out,
   input wire              branch_taken_out,
   input wire [7:0]        status_flags_out,
   input wire              flags_wr_en_in,
   input wire              io_rd_en_out,
   input wire              io_we_out,
   input wire              result_valid_out
);
////////////////////////////////////////////////////////////////////////////////
wire            acc    = op_valid_in & op_ready_out;     // request taken
wire            acc_br = acc & (op_code_in <= `CBX_OP_BR_IRQ_DIS);
wire            acc_io = acc & ((op_code_in == `CBX_OP_IO_SET) | (op_code_in == `CBX_OP_IO_CLR));
wire            acc_ro = acc & (op_code_in >= `CBX_OP_SHL) & (op_code_in <= `CBX_OP_BLD);
wire            acc_rw = acc_ro & (op_code_in != `CBX_OP_BST); // writes a register
wire [7:0]      f      = status_flags_out;
wire            nv     = f[2] ^ f[3];
// branch condition per code, lowest code at bit 0
wire [16:0]     cond   = {~f[7], f[7], ~f[3], ~f[6], f[6], ~f[5], f[5], nv, ~nv,
                          ~f[2], f[2], ~f[0], f[0], ~f[1], f[1], f[op_flag_sel_in],
                          ~f[op_flag_sel_in]};
wire            take_now = cond[op_code_in];
wire [PC_W-1:0] disp_ext = {{(PC_W-DISP_W){op_disp_in[DISP_W-1]}}, op_disp_in};
reg             prev_reg; // forwarded flags are not yet on the port, skip those cycles
// remember a register op taken one cycle back
always @(posedge clock_in or posedge sys_rst_in) begin
   if (sys_rst_in)
      prev_reg <= 1'b0;
   else
      prev_reg <= acc_ro;
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clock_in); endclocking
default disable iff (sys_rst_in);
property p_br_decide;
   acc_br && !prev_reg |=> branch_taken_out == $past(take_now);
endproperty
a_br_decide: assert property (p_br_decide)
   else $error("branch decision wrong");
property p_br_target;
   acc_br |=> pc_out == $past(pc_out) + 1'b1 + (branch_taken_out ? $past(disp_ext) : 1'b0);
endproperty
a_br_target: assert property (p_br_target) else $error("branch target wrong");
property p_br_cycles;
   // after a fall-through the next op may itself stall, so only a bubble must end
   acc_br |=> (branch_taken_out != op_ready_out) ##1 (op_ready_out || $past(op_ready_out));
endproperty
a_br_cycles: assert property (p_br_cycles) else $error("branch cycle count wrong");
property p_br_flags;
   acc_br && !flags_wr_en_in && !prev_reg |=> $stable(status_flags_out);
endproperty
a_br_flags: assert property (p_br_flags) else $error("branch changed flags");
property p_io_seq;
   acc_io |=> io_rd_en_out && !op_ready_out ##1 io_we_out && op_ready_out && !io_rd_en_out;
endproperty
a_io_seq: assert property (p_io_seq) else $error("io bit op sequence wrong");
property p_reg_result;
   acc_rw |=> op_ready_out ##1 result_valid_out;
endproperty
a_reg_result: assert property (p_reg_result) else $error("result pulse missing");
property p_no_stray;
   result_valid_out |-> $past(acc_rw, 2);
endproperty
a_no_stray: assert property (p_no_stray) else $error("result pulse unasked");
property p_bst_only_t;
   (acc && op_code_in == `CBX_OP_BST && !flags_wr_en_in) ##1 !flags_wr_en_in
      |=> (status_flags_out & 8'hBF) == ($past(status_flags_out) & 8'hBF);
endproperty
a_bst_only_t: assert property (p_bst_only_t) else $error("bit store touched flags");
c_taken: cover property (acc_br ##1 branch_taken_out);
c_io: cover property (acc_io ##2 io_we_out);
c_shift: cover property (acc_rw ##2 result_valid_out);
endmodule
bind cbx_exec cbx_exec_props #(.PC_W(PC_W), .DISP_W(DISP_W)) u_props (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
   .op_code_in(op_code_in), .op_flag_sel_in(op_flag_sel_in), .op_disp_in(op_disp_in),
   .op_ready_out(op_ready_out), .pc_out(pc_out), .branch_taken_out(branch_taken_out),
   .status_flags_out(status_flags_out), .flags_wr_en_in(flags_wr_en_in),
   .io_rd_en_out(io_rd_en_out), .io_we_out(io_we_out), .result_valid_out(result_valid_out));

// File: dv/cbx_exec_tb.sv
`timescale 1ns/100ps
`include "cbx_defines.vh"
module cbx_exec_tb;
reg        clock_in = 1'b0;
reg        sys_rst_in = 1'b1;
reg        op_valid_in = 1'b0;
reg  [4:0] op_code_in = 5'h1F;
reg  [2:0] op_flag_sel_in = 3'h0;
reg  [6:0] op_disp_in = 7'h00;
reg  [2:0] op_bit_sel_in = 3'h0;
reg  [4:0] op_reg_in = 5'h00;
reg  [4:0] op_io_addr_in = 5'h00;
reg        flags_wr_en_in = 1'b0;
reg  [7:0] flags_wr_data_in = 8'h00;
reg  [7:0] io_rdata_in = 8'h00;
reg        rf_wr_en_in = 1'b0;
reg  [4:0] rf_wr_addr_in = 5'h00;
reg  [7:0] rf_wr_data_in = 8'h00;
wire       op_ready_out, branch_taken_out, io_rd_en_out, io_we_out, result_valid_out;
wire [15:0] pc_out;
wire [7:0] status_flags_out, io_wdata_out, result_out;
wire [4:0] io_addr_out;
integer    n_fail = 0, tests_run = 0, cyc = 0, i, j;
reg  [7:0] pats [0:2];
cbx_exec u_dut (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
   .op_code_in(op_code_in), .op_flag_sel_in(op_flag_sel_in), .op_disp_in(op_disp_in),
   .op_bit_sel_in(op_bit_sel_in), .op_reg_in(op_reg_in), .op_io_addr_in(op_io_addr_in),
   .op_ready_out(op_ready_out), .pc_out(pc_out), .branch_taken_out(branch_taken_out),
   .status_flags_out(status_flags_out), .flags_wr_en_in(flags_wr_en_in),
   .flags_wr_data_in(flags_wr_data_in), .io_addr_out(io_addr_out),
   .io_rd_en_out(io_rd_en_out), .io_rdata_in(io_rdata_in), .io_wdata_out(io_wdata_out),
   .io_we_out(io_we_out), .rf_wr_en_in(rf_wr_en_in), .rf_wr_addr_in(rf_wr_addr_in),
   .rf_wr_data_in(rf_wr_data_in), .result_out(result_out),
   .result_valid_out(result_valid_out));
////////////////////////////////////////////////////////////////////////////////
// 20 MHz clock
always #25 clock_in = ~clock_in;
// hang guard, the whole run needs well under 1000 cycles
always @(posedge clock_in) begin
   cyc = cyc + 1;
   if (cyc == 3000) begin
      n_fail = n_fail + 1;
      results;
   end
end
task tick;
   @(negedge clock_in);
endtask
// one compare for every value, an unknown bit matches only an unknown expected bit
task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
   begin
      tests_run = tests_run + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   end
endtask
// load flags and one register together, visible at the next falling edge
task preload(input [7:0] f, input [4:0] r, input [7:0] v);
   begin
      flags_wr_en_in = 1'b1;
      flags_wr_data_in = f;
      rf_wr_en_in = 1'b1;
      rf_wr_addr_in = r;
      rf_wr_data_in = v;
      tick;
      flags_wr_en_in = 1'b0;
      rf_wr_en_in = 1'b0;
   end
endtask
// expected branch decision per code, flag order I T H S V N Z C
function exp_take(input [4:0] c, input [2:0] s, input [7:0] f);
   reg [16:0] v;
   begin
      v = {~f[7], f[7], ~f[3], ~f[6], f[6], ~f[5], f[5], f[2] ^ f[3], ~(f[2] ^ f[3]),
           ~f[2], f[2], ~f[0], f[0], ~f[1], f[1], f[s], ~f[s]};
      exp_take = v[c];
   end
endfunction
////////////////////////////////////////////////////////////////////////////////
// one branch; a no-op is held in the stall cycle and must be refused
task br(input [4:0] c, input [2:0] s, input [6:0] k, input [7:0] f);
   reg        t;
   reg [15:0] p;
   begin
      preload(f, 5'h1F, 8'h00);
      p = pc_out + 16'h0001 + {{9{k[6]}}, k};
      t = exp_take(c, s, f);
      op_code_in = c;
      op_flag_sel_in = s;
      op_disp_in = k;
      op_valid_in = 1'b1;
      tick;
      op_code_in = 5'h1F;
      op_valid_in = t;
      if (!t)
         p = p - {{9{k[6]}}, k};
      chk("taken", t, branch_taken_out);
      chk("pc", p, pc_out);
      chk("ready", !t, op_ready_out);
      chk("flags", f, status_flags_out);
      tick;
      op_valid_in = 1'b0;
      chk("stall pc", p, pc_out);
   end
endtask
// io read-modify-write of one bit
task io(input [4:0] c, input [2:0] b, input [7:0] rd, input [7:0] e);
   begin
      op_code_in = c;
      op_io_addr_in = 5'h15;
      op_bit_sel_in = b;
      io_rdata_in = rd;
      op_valid_in = 1'b1;
      tick;
      op_valid_in = 1'b0;
      chk("io read", 1, io_rd_en_out);
      chk("io addr", 5'h15, io_addr_out);
      tick;
      chk("io write", 1, io_we_out);
      chk("io data", e, io_wdata_out);
      io_rdata_in = ~rd;
   end
endtask
// shift, rotate or bit load on register 3 with T set
task sh(input [4:0] c, input [7:0] v, input cin);
   reg [7:0] e, ef;
   reg       co;
   begin
      preload(8'hE0 | cin, 5'h03, v);
      op_code_in = c;
      op_reg_in = 5'h03;
      op_bit_sel_in = 3'h3;
      op_valid_in = 1'b1;
      case (c)
         `CBX_OP_SHL: {co, e} = {v, 1'b0};
         `CBX_OP_SHR: {e, co} = {1'b0, v};
         `CBX_OP_ASR: {e, co} = {v[7], v};
         `CBX_OP_ROL: {co, e} = {v, cin};
         `CBX_OP_ROR: {e, co} = {cin, v};
         default:     {co, e} = {cin, v | 8'h08};
      endcase
      ef = (c == `CBX_OP_BLD) ? (8'hE0 | cin) : {4'hE, e[7] ^ co, e[7], e == 8'h00, co};
      tick;
      op_valid_in = 1'b0;
      tick;
      chk("result", e, result_out);
      chk("result valid", 1, result_valid_out);
      chk("shift flags", ef, status_flags_out);
   end
endtask
// two shifts on one register back to back, then a branch on the fresh zero flag
task fwd;
   reg [15:0] p;
   begin
      preload(8'h00, 5'h03, 8'h40);
      p = pc_out + 16'h0008;
      op_code_in = `CBX_OP_SHL;
      op_reg_in = 5'h03;
      op_valid_in = 1'b1;
      tick;
      tick;
      chk("fwd first result", 8'h80, result_out);
      op_code_in = `CBX_OP_BR_ZERO;
      op_disp_in = 7'h05;
      tick;
      op_code_in = 5'h1F;
      op_valid_in = 1'b0;
      chk("fwd result", 8'h00, result_out);
      chk("fwd flags", 8'h0B, status_flags_out);
      chk("fwd taken", 1, branch_taken_out);
      chk("fwd pc", p, pc_out);
      tick;
      op_code_in = 5'h1A;
      op_valid_in = 1'b1;
      tick;
      op_valid_in = 1'b0;
      chk("no-op pc", p + 16'h0001, pc_out);
   end
endtask
task results;
   begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
   pats[0] = 8'h00;
   pats[1] = 8'hFF;
   pats[2] = 8'h04;
   repeat (5) tick;
   sys_rst_in = 1'b0;
   chk("reset pc", 16'h0000, pc_out);
   chk("reset flags", 8'h00, status_flags_out);
   $display("test reset done");
   for (i = 0; i < 17; i = i + 1) begin
      for (j = 0; j < 3; j = j + 1) begin
         br(i[4:0], i[2:0], i[0] ? 7'h7C : 7'h05, pats[j]);
      end
   end
   $display("test branches done");
   io(`CBX_OP_IO_SET, 3'h7, 8'h00, 8'h80);
   io(`CBX_OP_IO_CLR, 3'h0, 8'hFF, 8'hFE);
   $display("test io bits done");
   sh(`CBX_OP_SHL, 8'h81, 1'b0);
   sh(`CBX_OP_SHR, 8'h01, 1'b0);
   sh(`CBX_OP_ASR, 8'h82, 1'b1);
   sh(`CBX_OP_ROL, 8'h80, 1'b1);
   sh(`CBX_OP_ROR, 8'h01, 1'b1);
   sh(`CBX_OP_BLD, 8'h00, 1'b0);
   preload(8'hBF, 5'h03, 8'h10);
   op_code_in = `CBX_OP_BST;
   op_bit_sel_in = 3'h4;
   op_valid_in = 1'b1;
   tick;
   op_valid_in = 1'b0;
   tick;
   chk("bit store flags", 8'hFF, status_flags_out);
   chk("bit store no result", 0, result_valid_out);
   $display("test register ops done");
   fwd;
   $display("test forwarding done");
   results;
end
endmodule

// File: logic/cbx_defines.vh
`ifndef CBX_DEFINES_VH
`define CBX_DEFINES_VH

// status flag positions inside status_flags_out
`define CBX_FLAG_C           3'd0
`define CBX_FLAG_Z           3'd1
`define CBX_FLAG_N           3'd2
`define CBX_FLAG_V           3'd3
`define CBX_FLAG_S           3'd4
`define CBX_FLAG_H           3'd5
`define CBX_FLAG_T           3'd6
`define CBX_FLAG_I           3'd7

// reset values and byte constants
`define CBX_RST_FLAGS        8'h00
`define CBX_RST_BYTE         8'h00
`define CBX_ZERO_BYTE        8'h00
`define CBX_ONE_HOT_BIT      8'h01

// operation codes on op_code_in
`define CBX_OP_BR_FLAG_CLR   5'h00
`define CBX_OP_BR_FLAG_SET   5'h01
`define CBX_OP_BR_ZERO       5'h02
`define CBX_OP_BR_NONZERO    5'h03
`define CBX_OP_BR_CARRY      5'h04
`define CBX_OP_BR_LOWER      5'h04
`define CBX_OP_BR_NO_CARRY   5'h05
`define CBX_OP_BR_SAME_HIGH  5'h05
`define CBX_OP_BR_NEGATIVE   5'h06
`define CBX_OP_BR_POSITIVE   5'h07
`define CBX_OP_BR_SIGNED_GE  5'h08
`define CBX_OP_BR_SIGNED_LT  5'h09
`define CBX_OP_BR_HC_SET     5'h0A
`define CBX_OP_BR_HC_CLR     5'h0B
`define CBX_OP_BR_T_SET      5'h0C
`define CBX_OP_BR_T_CLR      5'h0D
`define CBX_OP_BR_NO_OVF     5'h0E
`define CBX_OP_BR_IRQ_EN     5'h0F
`define CBX_OP_BR_IRQ_DIS    5'h10
`define CBX_OP_IO_SET        5'h11
`define CBX_OP_IO_CLR        5'h12
`define CBX_OP_SHL           5'h13
`define CBX_OP_SHR           5'h14
`define CBX_OP_ASR           5'h15
`define CBX_OP_ROL           5'h16
`define CBX_OP_ROR           5'h17
`define CBX_OP_BST           5'h18
`define CBX_OP_BLD           5'h19

`endif

// File: logic/cbx_exec.v
// Functional notes
// - flag-clear branch jumps to PC+k+1, 1/2 cycles
// - zero branches test Z set or clear
// - carry branches and aliases test C
// - negative and positive branches test N
// - signed branches test N xor V
// - half-carry branches test H, flags kept
// - transfer-flag branches test T, 1/2 cycles
// - no-overflow branch tests V clear
// - interrupt-state branches test I flag
// - io bit set/clear, 2 cycles, no flags
// - logical/arith shifts update Z C N V
// - rotates through carry update Z C N V
// - register bit copied into T only
// - T copied into one register bit
`timescale 1ns/100ps
`include "cbx_defines.vh"
module cbx_exec #(
   parameter PC_W   = 16,
   parameter DISP_W = 7,
   parameter IO_AW  = 5,
   parameter RF_AW  = 5
) (
   input  wire              clock_in,
   input  wire              sys_rst_in,
   input  wire              op_valid_in,
   input  wire [4:0]        op_code_in,
   input  wire [2:0]        op_flag_sel_in,
   input  wire [DISP_W-1:0] op_disp_in,
   input  wire [2:0]        op_bit_sel_in,
   input  wire [RF_AW-1:0]  op_reg_in,
   input  wire [IO_AW-1:0]  op_io_addr_in,
   output reg               op_ready_out,
   output reg  [PC_W-1:0]   pc_out,
   output reg               branch_taken_out,
   output reg  [7:0]        status_flags_out,
   input  wire              flags_wr_en_in,
   input  wire [7:0]        flags_wr_data_in,
   output reg  [IO_AW-1:0]  io_addr_out,
   output reg               io_rd_en_out,
   input  wire [7:0]        io_rdata_in,
   output reg  [7:0]        io_wdata_out,
   output reg               io_we_out,
   input  wire              rf_wr_en_in,
   input  wire [RF_AW-1:0]  rf_wr_addr_in,
   input  wire [7:0]        rf_wr_data_in,
   output reg  [7:0]        result_out,
   output reg               result_valid_out
);

   ////////////////////////////////////////////////////////////////////////
   // states and helpers

   localparam ST_RUN    = 2'b00;  // accepting operations
   localparam ST_BUBBLE = 2'b01;  // second cycle of a taken branch
   localparam ST_IO_RMW = 2'b10;  // io read phase of set/clear

   // branch condition of every branch opcode against a flag byte
   function br_take;
      input [4:0] op;
      input [2:0] sel;
      input [7:0] f;
      begin
         case (op)
            `CBX_OP_BR_FLAG_CLR:  br_take = ~f[sel];
            `CBX_OP_BR_FLAG_SET:  br_take = f[sel];
            `CBX_OP_BR_ZERO:      br_take = f[`CBX_FLAG_Z];
            `CBX_OP_BR_NONZERO:   br_take = ~f[`CBX_FLAG_Z];
            `CBX_OP_BR_CARRY:     br_take = f[`CBX_FLAG_C];
            `CBX_OP_BR_NO_CARRY:  br_take = ~f[`CBX_FLAG_C];
            `CBX_OP_BR_NEGATIVE:  br_take = f[`CBX_FLAG_N];
            `CBX_OP_BR_POSITIVE:  br_take = ~f[`CBX_FLAG_N];
            `CBX_OP_BR_SIGNED_GE: br_take = ~(f[`CBX_FLAG_N] ^ f[`CBX_FLAG_V]);
            `CBX_OP_BR_SIGNED_LT: br_take = f[`CBX_FLAG_N] ^ f[`CBX_FLAG_V];
            `CBX_OP_BR_HC_SET:    br_take = f[`CBX_FLAG_H];
            `CBX_OP_BR_HC_CLR:    br_take = ~f[`CBX_FLAG_H];
            `CBX_OP_BR_T_SET:     br_take = f[`CBX_FLAG_T];
            `CBX_OP_BR_T_CLR:     br_take = ~f[`CBX_FLAG_T];
            `CBX_OP_BR_NO_OVF:    br_take = ~f[`CBX_FLAG_V];
            `CBX_OP_BR_IRQ_EN:    br_take = f[`CBX_FLAG_I];
            `CBX_OP_BR_IRQ_DIS:   br_take = ~f[`CBX_FLAG_I];
            default:              br_take = 1'b0;
         endcase
      end
   endfunction

   // opcodes handled in the execute stage against the register array
   function is_reg_op;
      input [4:0] op;
      begin
         is_reg_op = (op >= `CBX_OP_SHL) && (op <= `CBX_OP_BLD);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   reg  [1:0]       state;        // issue state
   reg              ex_valid;     // execute stage holds a register op
   reg  [4:0]       ex_op;        // its opcode
   reg  [RF_AW-1:0] ex_reg;       // its register
   reg  [2:0]       ex_bit;       // its bit select
   reg              ex_fwd;       // operand comes from previous result
   reg  [7:0]       ex_fwd_data;  // forwarded operand
   reg              io_clr;       // pending io op clears instead of sets
   reg  [2:0]       io_bit;       // pending io bit
   wire [7:0]       rf_rdata;     // registered array read

   // execute stage results
   reg  [7:0]       operand;
   reg  [7:0]       ex_val;
   reg  [7:0]       ex_flags;
   reg              ex_c;
   reg              ex_shift;
   reg              ex_wr;
   reg              ex_fl_we;

   ////////////////////////////////////////////////////////////////////////
   // issue decode

   wire            accept  = op_valid_in & op_ready_out;
   wire            is_br   = op_code_in <= `CBX_OP_BR_IRQ_DIS;
   wire            is_io   = (op_code_in == `CBX_OP_IO_SET) |
                             (op_code_in == `CBX_OP_IO_CLR);
   // branches see flags that the execute stage writes this cycle
   wire [7:0]      flags_eff = ex_fl_we ? ex_flags : status_flags_out;
   wire            taken   = accept & is_br &
                             br_take(op_code_in, op_flag_sel_in, flags_eff);
   // displacement is a signed word offset
   wire [PC_W-1:0] disp_ext = {{(PC_W-DISP_W){op_disp_in[DISP_W-1]}}, op_disp_in};
   wire [PC_W-1:0] pc_inc   = pc_out + {{(PC_W-1){1'b0}}, 1'b1};
   wire [PC_W-1:0] pc_tgt   = pc_inc + disp_ext;
   wire [7:0]      io_mask  = `CBX_ONE_HOT_BIT << io_bit;

   ////////////////////////////////////////////////////////////////////////
   // execute stage: shifts, rotates and transfer-flag moves

   always @* begin
      operand  = ex_fwd ? ex_fwd_data : rf_rdata;
      ex_val   = operand;
      ex_flags = status_flags_out;
      ex_c     = status_flags_out[`CBX_FLAG_C];
      ex_shift = 1'b0;
      ex_wr    = 1'b0;
      ex_fl_we = 1'b0;
      if (ex_valid) begin
         case (ex_op)
            `CBX_OP_SHL: begin
               ex_val   = {operand[6:0], 1'b0};
               ex_c     = operand[7];
               ex_shift = 1'b1;
            end
            `CBX_OP_SHR: begin
               ex_val   = {1'b0, operand[7:1]};
               ex_c     = operand[0];
               ex_shift = 1'b1;
            end
            `CBX_OP_ASR: begin
               ex_val   = {operand[7], operand[7:1]};
               ex_c     = operand[0];
               ex_shift = 1'b1;
            end
            `CBX_OP_ROL: begin
               ex_val   = {operand[6:0], status_flags_out[`CBX_FLAG_C]};
               ex_c     = operand[7];
               ex_shift = 1'b1;
            end
            `CBX_OP_ROR: begin
               ex_val   = {status_flags_out[`CBX_FLAG_C], operand[7:1]};
               ex_c     = operand[0];
               ex_shift = 1'b1;
            end
            `CBX_OP_BST: begin
               ex_flags[`CBX_FLAG_T] = operand[ex_bit];
               ex_fl_we = 1'b1;
            end
            `CBX_OP_BLD: begin
               ex_val[ex_bit] = status_flags_out[`CBX_FLAG_T];
               ex_wr = 1'b1;
            end
            default: begin
               ex_wr = 1'b0;
            end
         endcase
      end
      // shift group writes the register and Z C N V; S is left alone
      if (ex_shift) begin
         ex_wr    = 1'b1;
         ex_fl_we = 1'b1;
         ex_flags[`CBX_FLAG_Z] = (ex_val == `CBX_ZERO_BYTE);
         ex_flags[`CBX_FLAG_N] = ex_val[7];
         ex_flags[`CBX_FLAG_C] = ex_c;
         ex_flags[`CBX_FLAG_V] = ex_val[7] ^ ex_c;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register array; core write wins over the external load port

   cbx_regfile #(
      .DW (8),
      .AW (RF_AW)
   ) u_regfile (
      .clock_in    (clock_in),
      .sys_rst_in  (sys_rst_in),
      .wr_en_in    (ex_wr | rf_wr_en_in),
      .wr_addr_in  (ex_wr ? ex_reg : rf_wr_addr_in),
      .wr_data_in  (ex_wr ? ex_val : rf_wr_data_in),
      .rd_addr_in  (op_reg_in),
      .rd_data_out (rf_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // issue, program counter and io read-modify-write

   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state            <= ST_RUN;
         op_ready_out     <= 1'b1;
         pc_out           <= {PC_W{1'b0}};
         branch_taken_out <= 1'b0;
         io_addr_out      <= {IO_AW{1'b0}};
         io_rd_en_out     <= 1'b0;
         io_wdata_out     <= `CBX_RST_BYTE;
         io_we_out        <= 1'b0;
         io_clr           <= 1'b0;
         io_bit           <= 3'd0;
         ex_valid         <= 1'b0;
         ex_op            <= `CBX_OP_BR_FLAG_CLR;
         ex_reg           <= {RF_AW{1'b0}};
         ex_bit           <= 3'd0;
         ex_fwd           <= 1'b0;
         ex_fwd_data      <= `CBX_RST_BYTE;
      end else begin
         branch_taken_out <= taken;
         io_we_out        <= 1'b0;
         io_rd_en_out     <= 1'b0;
         // execute stage loads one register op per accepted cycle
         ex_valid    <= accept & is_reg_op(op_code_in);
         ex_op       <= op_code_in;
         ex_reg      <= op_reg_in;
         ex_bit      <= op_bit_sel_in;
         // back-to-back ops on one register take the fresh result
         ex_fwd      <= ex_wr & (ex_reg == op_reg_in);
         ex_fwd_data <= ex_val;
         case (state)
            ST_RUN: begin
               if (accept) begin
                  // taken branch: target and one extra cycle
                  pc_out <= taken ? pc_tgt : pc_inc;
                  if (taken) begin
                     state        <= ST_BUBBLE;
                     op_ready_out <= 1'b0;
                  end else if (is_io) begin
                     state        <= ST_IO_RMW;
                     op_ready_out <= 1'b0;
                     io_addr_out  <= op_io_addr_in;
                     io_rd_en_out <= 1'b1;
                     io_clr       <= (op_code_in == `CBX_OP_IO_CLR);
                     io_bit       <= op_bit_sel_in;
                  end
               end
            end
            ST_BUBBLE: begin
               state        <= ST_RUN;
               op_ready_out <= 1'b1;
            end
            ST_IO_RMW: begin
               // other bits of the io register written back as read
               io_wdata_out <= io_clr ? (io_rdata_in & ~io_mask)
                                      : (io_rdata_in | io_mask);
               io_we_out    <= 1'b1;
               state        <= ST_RUN;
               op_ready_out <= 1'b1;
            end
            default: begin
               state        <= ST_RUN;
               op_ready_out <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags and result report

   // an instruction's flag update wins over an external flag load
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_flags_out <= `CBX_RST_FLAGS;
         result_out       <= `CBX_RST_BYTE;
         result_valid_out <= 1'b0;
      end else begin
         if (ex_fl_we) begin
            status_flags_out <= ex_flags;
         end else if (flags_wr_en_in) begin
            status_flags_out <= flags_wr_data_in;
         end
         result_valid_out <= ex_wr;
         if (ex_wr) begin
            result_out <= ex_val;
         end
      end
   end

endmodule

// File: logic/cbx_regfile.v
`timescale 1ns/100ps
// working register array, one write port, one registered read port
module cbx_regfile #(
   parameter DW = 8,
   parameter AW = 5
) (
   input  wire          clock_in,
   input  wire          sys_rst_in,
   input  wire          wr_en_in,
   input  wire [AW-1:0] wr_addr_in,
   input  wire [DW-1:0] wr_data_in,
   input  wire [AW-1:0] rd_addr_in,
   output reg  [DW-1:0] rd_data_out
);

   reg [DW-1:0] mem [0:(1<<AW)-1];   // storage, not reset

   // write port; array carries no reset to stay memory-like
   always @(posedge clock_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // read data registered; a same-cycle write shows old data
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_data_out <= {DW{1'b0}};
      end else begin
         rd_data_out <= mem[rd_addr_in];
      end
   end

endmodule
